// >>> heat_reg_pkg.sv
// Constants, register map and carrier types of the channel heating regulator.
package heat_reg_pkg;

	// ----------------------------------------------------------------
	// Channels and timing
	// ----------------------------------------------------------------
	localparam int NUM_CH = 7;
	localparam logic [2:0] NUM_CH_IDX = 3'h7;
	localparam int DEFAULT_ACTIVE_CH = 1;
	localparam longint unsigned CLK_HZ = 64'h0000_0000_02FA_F080;
	localparam longint unsigned MINUTE_S = 64'h0000_0000_0000_003C;
	localparam longint unsigned CYCLES_PER_MINUTE = CLK_HZ * MINUTE_S;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] STATUS_ADDR = 12'h100;
	localparam logic [3:0] CH_PAGE = 4'h0;
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_SETPOINT = 3'h1;
	localparam logic [2:0] OFS_HYST = 3'h2;
	localparam logic [2:0] OFS_ALARM_MIN = 3'h3;
	localparam logic [2:0] OFS_ALARM_MAX = 3'h4;
	localparam logic [2:0] OFS_PERIOD = 3'h5;
	localparam logic [2:0] OFS_ON_TIME = 3'h6;
	localparam logic [2:0] OFS_MANUAL_TIME = 3'h7;

	localparam int CTRL_ACTIVE = 0;
	localparam int CTRL_OPEN_ON_HEAT = 1;
	localparam int CTRL_DUTY_MODE = 2;
	localparam int CTRL_ALARM_EN = 3;
	localparam int CTRL_MANUAL_ON = 4;
	localparam int CTRL_MANUAL_START = 5;
	localparam int CTRL_SENSOR_LSB = 8;
	localparam int CTRL_SENSOR_MSB = 10;
	localparam int STAT_HEAT_LSB = 0;
	localparam int STAT_ALARM_LSB = 8;
	localparam int STAT_MANUAL_LSB = 16;

	// ----------------------------------------------------------------
	// Ranges and defaults, temperatures in tenths of a degree
	// ----------------------------------------------------------------
	localparam logic signed [15:0] SETPOINT_MIN = 16'shFE0C;
	localparam logic signed [15:0] SETPOINT_MAX = 16'sh07D0;
	localparam logic signed [15:0] SETPOINT_DEF = 16'sh0032;
	localparam logic signed [15:0] HYST_MIN = 16'sh0002;
	localparam logic signed [15:0] HYST_MAX = 16'sh005A;
	localparam logic signed [15:0] HYST_DEF = 16'sh0004;
	localparam logic signed [15:0] ALARM_HYST = 16'sh0002;
	localparam logic signed [15:0] ALARM_MIN_DEF = 16'sh0000;
	localparam logic signed [15:0] ALARM_MAX_DEF = 16'sh0258;
	localparam logic [9:0] PERIOD_MIN = 10'h001;
	localparam logic [9:0] PERIOD_MAX = 10'h384;
	localparam logic [9:0] PERIOD_DEF = 10'h01E;
	localparam logic [9:0] ON_TIME_MIN = 10'h000;
	localparam logic [9:0] ON_TIME_DEF = 10'h00F;
	localparam logic [9:0] MANUAL_TIME_DEF = 10'h001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic signed [15:0] temp_t;

	typedef enum logic [2:0] {
		SENSOR_0, SENSOR_1, SENSOR_2, SENSOR_3,
		SENSOR_4, SENSOR_5, SENSOR_6, SENSOR_7
	} sensor_type_t;

	typedef struct packed {
		logic active;
		logic relay_open_on_heat;
		logic duty_cycle_mode;
		logic alarm_en;
		logic manual_heat_on;
		sensor_type_t sensor_type;
		temp_t setpoint;
		temp_t hyst;
		temp_t alarm_min;
		temp_t alarm_max;
		logic [9:0] period;
		logic [9:0] on_time;
		logic [9:0] manual_time;
	} chan_cfg_t;

	typedef struct packed {
		logic heat;
		logic relay_closed;
		logic alarm;
		logic manual_run;
	} chan_out_t;

endpackage : heat_reg_pkg

// >>> channel_heating_regulator.sv
// Seven-channel heating regulator with an APB register slave.
//
// Functional notes
// (RQ1) Seven channels, each set active or inactive on its own.
// (RQ2) Inactive channel regulates nothing and drives no heating output.
// (RQ3) After reset only channel two is active.
// (RQ4) Per-channel relay polarity: open-on-heat or closed-on-heat.
// (RQ5) Relay polarity resets to closed-on-heat.
// (RQ6) Single-sensor mode heats below setpoint, stops above it.
// (RQ7) Setpoint accepted from -50 to 200 C, default 5 C.
// (RQ8) Hysteresis accepted from 0.2 to 9 C, default 0.4 C.
// (RQ9) Off at setpoint plus hysteresis, on at setpoint minus it, else hold.
// (RQ10) Alarm enable, min and max; defaults off, 0 C, 60 C.
// (RQ11) Enabled alarm flags readings outside window, 0.2 C hysteresis; the code holds the alarm low in duty mode.
// (RQ12) Eight sensor types selectable per channel.
// (RQ13) Sensor type changes only accepted on active channels.
// (RQ14) Duty mode heats while period counter is below on-time.
// (RQ15) Period accepted from 1 to 900 minutes, default 30.
// (RQ16) On-time counts from period start, default 15 minutes.
// (RQ17) Manual override starts only on a running channel, then resumes mode.
// (RQ18) Manual override duration per channel, default one minute.
// (RQ19) Override forces heating on or off per channel, default off.
// (RQ20) Override start control defaults to stop, returns to stop on expiry.
// (RQ21) Period counter restarts at zero at each period end.
// (RQ22) Stopping the override early resumes regulation at once.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module channel_heating_regulator #(
	parameter longint unsigned CYCLES_PER_MINUTE = heat_reg_pkg::CYCLES_PER_MINUTE
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire heat_reg_pkg::temp_t [6:0] temp_in,
	output heat_reg_pkg::sensor_type_t [6:0] sensor_type,
	output heat_reg_pkg::chan_out_t [6:0] chan_out
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic signed [16:0] v, input logic signed [16:0] lo,
		input logic signed [16:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic signed [16:0] widen(input heat_reg_pkg::temp_t v);
		widen = {v[15], v};
	endfunction : widen

	function automatic logic [9:0] next_minute(input logic [9:0] cnt, input logic [9:0] limit);
		logic [10:0] inc;
		inc = {1'b0, cnt} + 11'h001;
		if (inc >= {1'b0, limit})
		begin
			next_minute = 10'h000;
		end
		else
		begin
			next_minute = inc[9:0];
		end
	endfunction : next_minute

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	heat_reg_pkg::chan_cfg_t cfg [heat_reg_pkg::NUM_CH];
	logic [9:0] dc_cnt [heat_reg_pkg::NUM_CH];
	logic [9:0] man_cnt [heat_reg_pkg::NUM_CH];
	logic [6:0] thermo_heat;
	logic [6:0] alarm;
	logic [6:0] man_run;
	logic [31:0] tick_cnt;
	logic minute_tick;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic access;
	logic wr_en;
	logic [2:0] sel_ch;
	logic [2:0] sel_ofs;
	logic ch_hit;
	logic stat_hit;

	assign access = psel && penable;
	assign wr_en = access && pready && pwrite;
	assign sel_ch = paddr[7:5];
	assign sel_ofs = paddr[4:2];
	assign ch_hit = (paddr[11:8] == heat_reg_pkg::CH_PAGE) && (sel_ch < heat_reg_pkg::NUM_CH_IDX);
	assign stat_hit = (paddr == heat_reg_pkg::STATUS_ADDR);

	function automatic logic wr_hit(input logic en, input logic hit, input logic [2:0] ch,
		input logic [2:0] sch, input logic [2:0] ofs, input logic [2:0] sofs);
		wr_hit = en && hit && (ch == sch) && (ofs == sofs);
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// Minute time base
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 32'h0000_0000;
			minute_tick <= 1'b0;
		end
		else if (tick_cnt == 32'(CYCLES_PER_MINUTE - 64'h1))
		begin
			tick_cnt <= 32'h0000_0000;
			minute_tick <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			minute_tick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				cfg[c].active <= (c == heat_reg_pkg::DEFAULT_ACTIVE_CH); // [RQ1] [RQ3]
				cfg[c].relay_open_on_heat <= 1'b0; // [RQ5]
				cfg[c].duty_cycle_mode <= 1'b0;
				cfg[c].alarm_en <= 1'b0; // [RQ10]
				cfg[c].manual_heat_on <= 1'b0; // [RQ19]
				cfg[c].sensor_type <= heat_reg_pkg::SENSOR_0;
				cfg[c].setpoint <= heat_reg_pkg::SETPOINT_DEF; // [RQ7]
				cfg[c].hyst <= heat_reg_pkg::HYST_DEF; // [RQ8]
				cfg[c].alarm_min <= heat_reg_pkg::ALARM_MIN_DEF; // [RQ10]
				cfg[c].alarm_max <= heat_reg_pkg::ALARM_MAX_DEF; // [RQ10]
				cfg[c].period <= heat_reg_pkg::PERIOD_DEF; // [RQ15]
				cfg[c].on_time <= heat_reg_pkg::ON_TIME_DEF; // [RQ16]
				cfg[c].manual_time <= heat_reg_pkg::MANUAL_TIME_DEF; // [RQ18]
			end
		end
		else
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_CTRL, sel_ofs))
				begin
					cfg[c].active <= pwdata[heat_reg_pkg::CTRL_ACTIVE]; // [RQ1]
					cfg[c].relay_open_on_heat <= pwdata[heat_reg_pkg::CTRL_OPEN_ON_HEAT]; // [RQ4]
					cfg[c].duty_cycle_mode <= pwdata[heat_reg_pkg::CTRL_DUTY_MODE];
					cfg[c].alarm_en <= pwdata[heat_reg_pkg::CTRL_ALARM_EN]; // [RQ10]
					cfg[c].manual_heat_on <= pwdata[heat_reg_pkg::CTRL_MANUAL_ON]; // [RQ19]
					if (cfg[c].active)
					begin
						cfg[c].sensor_type <= heat_reg_pkg::sensor_type_t'(
							pwdata[heat_reg_pkg::CTRL_SENSOR_MSB:heat_reg_pkg::CTRL_SENSOR_LSB]); // [RQ12] [RQ13]
					end
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_SETPOINT, sel_ofs)
					&& in_range(widen(pwdata[15:0]), widen(heat_reg_pkg::SETPOINT_MIN),
					widen(heat_reg_pkg::SETPOINT_MAX)))
				begin
					cfg[c].setpoint <= pwdata[15:0]; // [RQ7]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_HYST, sel_ofs)
					&& in_range(widen(pwdata[15:0]), widen(heat_reg_pkg::HYST_MIN),
					widen(heat_reg_pkg::HYST_MAX)))
				begin
					cfg[c].hyst <= pwdata[15:0]; // [RQ8]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_ALARM_MIN, sel_ofs))
				begin
					cfg[c].alarm_min <= pwdata[15:0]; // [RQ10]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_ALARM_MAX, sel_ofs))
				begin
					cfg[c].alarm_max <= pwdata[15:0]; // [RQ10]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_PERIOD, sel_ofs)
					&& (pwdata[31:10] == 22'h00_0000)
					&& (pwdata[9:0] >= heat_reg_pkg::PERIOD_MIN)
					&& (pwdata[9:0] <= heat_reg_pkg::PERIOD_MAX))
				begin
					cfg[c].period <= pwdata[9:0]; // [RQ15]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_ON_TIME, sel_ofs)
					&& (pwdata[31:10] == 22'h00_0000)
					&& (pwdata[9:0] >= heat_reg_pkg::ON_TIME_MIN)
					&& (pwdata[9:0] <= heat_reg_pkg::PERIOD_MAX))
				begin
					cfg[c].on_time <= pwdata[9:0]; // [RQ16]
				end
				if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_MANUAL_TIME, sel_ofs)
					&& (pwdata[31:10] == 22'h00_0000)
					&& (pwdata[9:0] >= heat_reg_pkg::PERIOD_MIN)
					&& (pwdata[9:0] <= heat_reg_pkg::PERIOD_MAX))
				begin
					cfg[c].manual_time <= pwdata[9:0]; // [RQ18]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Thermostat with hysteresis and alarm window
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			thermo_heat <= 7'h00;
			alarm <= 7'h00;
		end
		else
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				if (!cfg[c].active || cfg[c].duty_cycle_mode)
				begin
					thermo_heat[c] <= 1'b0; // [RQ2]
					alarm[c] <= 1'b0;
				end
				else
				begin
					if (widen(temp_in[c]) >= widen(cfg[c].setpoint) + widen(cfg[c].hyst))
					begin
						thermo_heat[c] <= 1'b0; // [RQ6] [RQ9]
					end
					else if (widen(temp_in[c]) <= widen(cfg[c].setpoint) - widen(cfg[c].hyst))
					begin
						thermo_heat[c] <= 1'b1; // [RQ6] [RQ9]
					end
					if (!cfg[c].alarm_en)
					begin
						alarm[c] <= 1'b0; // [RQ10]
					end
					else if (!in_range(widen(temp_in[c]), widen(cfg[c].alarm_min),
						widen(cfg[c].alarm_max)))
					begin
						alarm[c] <= 1'b1; // [RQ11]
					end
					else if (in_range(widen(temp_in[c]),
						widen(cfg[c].alarm_min) + widen(heat_reg_pkg::ALARM_HYST),
						widen(cfg[c].alarm_max) - widen(heat_reg_pkg::ALARM_HYST)))
					begin
						alarm[c] <= 1'b0; // [RQ11]
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Duty-cycle period counters
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				dc_cnt[c] <= 10'h000;
			end
		end
		else
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				if (!cfg[c].active || !cfg[c].duty_cycle_mode)
				begin
					dc_cnt[c] <= 10'h000;
				end
				else if (minute_tick)
				begin
					dc_cnt[c] <= next_minute(dc_cnt[c], cfg[c].period); // [RQ21]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Manual override
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			man_run <= 7'h00; // [RQ20]
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				man_cnt[c] <= 10'h000;
			end
		end
		else
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				if (!cfg[c].active)
				begin
					man_run[c] <= 1'b0;
				end
				else if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_CTRL, sel_ofs)
					&& !pwdata[heat_reg_pkg::CTRL_MANUAL_START])
				begin
					man_run[c] <= 1'b0; // [RQ22]
				end
				else if (wr_hit(wr_en, ch_hit, 3'(c), sel_ch, heat_reg_pkg::OFS_CTRL, sel_ofs)
					&& !man_run[c] && pwdata[heat_reg_pkg::CTRL_ACTIVE])
				begin
					man_run[c] <= 1'b1; // [RQ17]
					man_cnt[c] <= 10'h000;
				end
				else if (man_run[c] && minute_tick)
				begin
					man_cnt[c] <= next_minute(man_cnt[c], cfg[c].manual_time); // [RQ18]
					if (next_minute(man_cnt[c], cfg[c].manual_time) == 10'h000)
					begin
						man_run[c] <= 1'b0; // [RQ20]
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chan_out <= '0;
		end
		else
		begin
			for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
			begin
				logic next_heat;
				next_heat = 1'b0;
				if (!cfg[c].active)
				begin
					next_heat = 1'b0; // [RQ2]
				end
				else if (man_run[c])
				begin
					next_heat = cfg[c].manual_heat_on; // [RQ19]
				end
				else if (cfg[c].duty_cycle_mode)
				begin
					next_heat = (dc_cnt[c] < cfg[c].on_time); // [RQ14] [RQ16]
				end
				else
				begin
					next_heat = thermo_heat[c]; // [RQ6]
				end
				chan_out[c].heat <= next_heat;
				chan_out[c].relay_closed <= next_heat ^ cfg[c].relay_open_on_heat; // [RQ4]
				chan_out[c].alarm <= alarm[c];
				chan_out[c].manual_run <= man_run[c];
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < heat_reg_pkg::NUM_CH; c++)
		begin
			sensor_type[c] = cfg[c].sensor_type; // [RQ12]
		end
	end

	// ----------------------------------------------------------------
	// APB read and handshake
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (access && !pready)
		begin
			pready <= 1'b1;
			pslverr <= !(ch_hit || stat_hit);
			prdata <= 32'h0000_0000;
			if (!pwrite && stat_hit)
			begin
				prdata[heat_reg_pkg::STAT_HEAT_LSB +: heat_reg_pkg::NUM_CH] <= thermo_heat;
				prdata[heat_reg_pkg::STAT_ALARM_LSB +: heat_reg_pkg::NUM_CH] <= alarm;
				prdata[heat_reg_pkg::STAT_MANUAL_LSB +: heat_reg_pkg::NUM_CH] <= man_run;
			end
			else if (!pwrite && ch_hit)
			begin
				unique case (sel_ofs)
					heat_reg_pkg::OFS_CTRL:
					begin
						prdata[heat_reg_pkg::CTRL_ACTIVE] <= cfg[sel_ch].active;
						prdata[heat_reg_pkg::CTRL_OPEN_ON_HEAT] <= cfg[sel_ch].relay_open_on_heat;
						prdata[heat_reg_pkg::CTRL_DUTY_MODE] <= cfg[sel_ch].duty_cycle_mode;
						prdata[heat_reg_pkg::CTRL_ALARM_EN] <= cfg[sel_ch].alarm_en;
						prdata[heat_reg_pkg::CTRL_MANUAL_ON] <= cfg[sel_ch].manual_heat_on;
						prdata[heat_reg_pkg::CTRL_MANUAL_START] <= man_run[sel_ch];
						prdata[heat_reg_pkg::CTRL_SENSOR_MSB:heat_reg_pkg::CTRL_SENSOR_LSB]
							<= cfg[sel_ch].sensor_type;
					end
					heat_reg_pkg::OFS_SETPOINT:
					begin
						prdata <= 32'(cfg[sel_ch].setpoint);
					end
					heat_reg_pkg::OFS_HYST:
					begin
						prdata <= 32'(cfg[sel_ch].hyst);
					end
					heat_reg_pkg::OFS_ALARM_MIN:
					begin
						prdata <= 32'(cfg[sel_ch].alarm_min);
					end
					heat_reg_pkg::OFS_ALARM_MAX:
					begin
						prdata <= 32'(cfg[sel_ch].alarm_max);
					end
					heat_reg_pkg::OFS_PERIOD:
					begin
						prdata <= {6'h00, dc_cnt[sel_ch], 6'h00, cfg[sel_ch].period};
					end
					heat_reg_pkg::OFS_ON_TIME:
					begin
						prdata[9:0] <= cfg[sel_ch].on_time;
					end
					heat_reg_pkg::OFS_MANUAL_TIME:
					begin
						prdata <= {6'h00, man_cnt[sel_ch], 6'h00, cfg[sel_ch].manual_time};
					end
				endcase
			end
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule : channel_heating_regulator

`default_nettype wire

// >>> heat_reg_chk.sv
// Port assertions for the channel heating regulator.
`timescale 1ns/1ps
`default_nettype none
module heat_reg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire heat_reg_pkg::temp_t [6:0] temp_in,
	input wire heat_reg_pkg::sensor_type_t [6:0] sensor_type,
	input wire heat_reg_pkg::chan_out_t [6:0] chan_out
);
	logic [6:0] wrc;
	logic [6:0] st;
	logic [6:0] sp;
	logic [6:0] act;
	logic [6:0] pol;
	logic [6:0] mon;
	logic [6:0] aen;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	always_comb
	begin
		for (int c = 0; c < 7; c++)
		begin
			wrc[c] = psel && penable && pready && pwrite && (paddr == 12'(c * 32));
			st[c] = wrc[c] && pwdata[5] && pwdata[0];
			sp[c] = wrc[c] && !pwdata[5];
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act <= 7'h02;
			pol <= 7'h00;
			mon <= 7'h00;
			aen <= 7'h00;
		end
		else
		begin
			for (int c = 0; c < 7; c++)
			begin
				if (wrc[c])
				begin
					act[c] <= pwdata[0];
					pol[c] <= pwdata[1];
					aen[c] <= pwdata[3];
					mon[c] <= pwdata[4];
				end
			end
		end
	end
	for (genvar c = 0; c < 7; c++)
	begin : g_ch
		AST_IDLE: assert property (!act[c] && !$past(act[c]) && !$past(act[c], 2)
			|-> !chan_out[c].heat && !chan_out[c].manual_run)
			else $error("Inactive channel drives its output.");
		AST_POLARITY: assert property (pol[c] == $past(pol[c]) && pol[c] == $past(pol[c], 2)
			|-> chan_out[c].relay_closed == (chan_out[c].heat ^ pol[c]))
			else $error("Relay level does not follow heat and polarity.");
		AST_SENSOR_LOCK: assert property ($changed(sensor_type[c]) |-> $past(act[c]))
			else $error("Sensor type changed on an inactive channel.");
		AST_OVR_START: assert property ($rose(chan_out[c].manual_run)
			|-> $past(st[c]) || $past(st[c], 2))
			else $error("Override started without a start write.");
		AST_OVR_STOP: assert property (sp[c] |-> ##2 !chan_out[c].manual_run)
			else $error("Override still running after a stop write.");
		AST_OVR_LEVEL: assert property (chan_out[c].manual_run && $past(chan_out[c].manual_run)
			&& $past(act[c]) && $stable(mon[c]) |-> chan_out[c].heat == mon[c])
			else $error("Override heat level differs from the setting.");
		AST_ALARM_OFF: assert property (!aen[c] && !$past(aen[c]) && !$past(aen[c], 2)
			|-> !chan_out[c].alarm)
			else $error("Alarm raised while alarm checking is off.");
	end
	AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("Bus answer not in the second access cycle.");
endmodule : heat_reg_chk
bind channel_heating_regulator heat_reg_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.temp_in(temp_in), .sensor_type(sensor_type), .chan_out(chan_out)
);
`default_nettype wire

// >>> sensor_load_model.sv
// Far-side temperature sensors and heating relays of the regulator.
`timescale 1ns/1ps
`default_nettype none
module sensor_load_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_en,
	input wire logic [2:0] set_ch,
	input wire heat_reg_pkg::temp_t set_val,
	input wire heat_reg_pkg::chan_out_t [6:0] chan_out,
	output heat_reg_pkg::temp_t [6:0] temp_out,
	output logic [6:0] contact_closed
);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			temp_out <= {7{16'sh00C8}};
		else if (set_en)
			temp_out[set_ch] <= set_val;
	end
	always_comb
	begin
		for (int c = 0; c < 7; c++)
			contact_closed[c] = chan_out[c].relay_closed;
	end
endmodule : sensor_load_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the channel heating regulator.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int CPM = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic set_en = 1'b0;
	logic [2:0] set_ch = 3'h0;
	heat_reg_pkg::temp_t set_val = 16'sh0000;
	heat_reg_pkg::temp_t [6:0] temp_in;
	heat_reg_pkg::sensor_type_t [6:0] sensor_type;
	heat_reg_pkg::chan_out_t [6:0] chan_out;
	logic [6:0] contact_closed;
	int mismatches = 0;
	int n_checks = 0;
	int cnt;
	logic [31:0] rd;
	logic er;
	logic [31:0] dfl [8] = '{32'h0, 32'h32, 32'h4, 32'h0, 32'h258, 32'h1E, 32'hF, 32'h1};
	logic [2:0] ro [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h5, 3'h5};
	logic [31:0] rv [6] = '{32'h7D1, 32'hFFFF_FE0C, 32'h1, 32'h5A, 32'h385, 32'h1};
	logic [31:0] re [6] = '{32'h32, 32'hFE0C, 32'h4, 32'h5A, 32'h1E, 32'h1};
	heat_reg_pkg::temp_t tv [6] = '{16'sh002E, 16'sh0032, 16'sh0036, 16'sh0032, 16'sh002E, 16'sh0035};
	logic [3:0] te [6] = '{4'hC, 4'hC, 4'h0, 4'h0, 4'hC, 4'hC};
	heat_reg_pkg::temp_t av [6] = '{16'shFFFF, 16'sh0001, 16'sh0002, 16'sh0259, 16'sh0257, 16'sh0259};
	logic ae [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [31:0] dn [3] = '{32'h0, 32'h1, 32'h3};
	always #10 pclk = ~pclk;
	channel_heating_regulator #(.CYCLES_PER_MINUTE(CPM)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.temp_in(temp_in), .sensor_type(sensor_type), .chan_out(chan_out)
	);
	sensor_load_model u_model (
		.pclk(pclk), .presetn(presetn), .set_en(set_en), .set_ch(set_ch), .set_val(set_val),
		.chan_out(chan_out), .temp_out(temp_in), .contact_closed(contact_closed)
	);
	function automatic logic [11:0] ra(input int c, input logic [2:0] o);
		return 12'(c * 32) | {7'h00, o, 2'b00};
	endfunction : ra
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(negedge pclk);
	endtask : apb
	task automatic tset(input int c, input heat_reg_pkg::temp_t v);
		@(posedge pclk);
		set_en <= 1'b1;
		set_ch <= 3'(c);
		set_val <= v;
		@(posedge pclk);
		set_en <= 1'b0;
		repeat (4) @(negedge pclk);
	endtask : tset
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		give_verdict();
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int c = 0; c < 7; c++)
		begin
			apb(1'b0, ra(c, 3'h0), 32'h0);
			chk("ctrl", rd, {31'h0, c == 1});
		end
		for (int o = 1; o < 8; o++)
		begin
			apb(1'b0, ra(1, 3'(o)), 32'h0);
			chk("default", rd & 32'h0000_FFFF, dfl[o]);
		end
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, ra(1, ro[i]), rv[i]);
			apb(1'b0, ra(1, ro[i]), 32'h0);
			chk("range", rd & 32'h0000_FFFF, re[i]);
		end
		apb(1'b1, ra(1, 3'h1), 32'h32);
		apb(1'b1, ra(1, 3'h2), 32'h4);
		apb(1'b1, 12'h0E0, 32'h1);
		chk("unmapped", {31'h0, er}, 32'h1);
		for (int i = 0; i < 6; i++)
		begin
			tset(1, tv[i]);
			chk("thermostat", 32'(chan_out[1]), {28'h0, te[i]});
		end
		apb(1'b1, ra(1, 3'h0), 32'h3);
		chk("contact", {31'h0, contact_closed[1]}, 32'h0);
		chk("open", 32'(chan_out[1]), 32'h8);
		apb(1'b1, ra(1, 3'h0), 32'h1);
		tset(0, 16'sh0000);
		chk("idle", 32'(chan_out[0]), 32'h0);
		apb(1'b1, ra(0, 3'h0), 32'h0000_0300);
		chk("type", 32'(sensor_type[0]), 32'h0);
		apb(1'b1, ra(0, 3'h0), 32'h1);
		for (int t = 7; t >= 0; t--)
		begin
			apb(1'b1, ra(0, 3'h0), {21'h0, 3'(t), 8'h01});
			chk("type", 32'(sensor_type[0]), t);
		end
		chk("active", 32'(chan_out[0]), 32'hC);
		apb(1'b1, ra(0, 3'h0), 32'h9);
		for (int i = 0; i < 6; i++)
		begin
			tset(0, av[i]);
			chk("alarm", {31'h0, chan_out[0].alarm}, {31'h0, ae[i]});
		end
		apb(1'b1, ra(0, 3'h0), 32'h1);
		chk("alarm", {31'h0, chan_out[0].alarm}, 32'h0);
		apb(1'b1, ra(2, 3'h5), 32'h3);
		apb(1'b1, ra(2, 3'h0), 32'h5);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, ra(2, 3'h6), dn[k]);
			repeat (3 * CPM) @(negedge pclk);
			cnt = 0;
			repeat (6 * CPM) @(negedge pclk) cnt += int'(chan_out[2].heat === 1'b1);
			chk("duty", cnt, dn[k] * 2 * CPM);
		end
		apb(1'b1, ra(3, 3'h0), 32'h30);
		chk("manual", 32'(chan_out[3]), 32'h0);
		tset(1, 16'sh0036);
		apb(1'b1, ra(1, 3'h0), 32'h31);
		chk("manual", 32'(chan_out[1]), 32'hD);
		repeat (2 * CPM) @(negedge pclk);
		chk("manual", 32'(chan_out[1]), 32'h0);
		apb(1'b0, ra(1, 3'h0), 32'h0);
		chk("start", rd & 32'h20, 32'h0);
		apb(1'b1, ra(1, 3'h7), 32'h5);
		tset(1, 16'sh002E);
		apb(1'b1, ra(1, 3'h0), 32'h21);
		chk("manual", 32'(chan_out[1]), 32'h1);
		apb(1'b1, ra(1, 3'h0), 32'h1);
		chk("manual", 32'(chan_out[1]), 32'hC);
		apb(1'b0, 12'h100, 32'h0);
		chk("status", {er, rd[30:0]}, 32'h2);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
